// >>> ossr_pkg.sv
// constants for the output source select register bank
package ossr_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OSSR_OFS_DAC = 8'h11;
  localparam logic [7:0] OSSR_OFS_PDM = 8'h12;
  localparam logic [7:0] OSSR_OFS_STATUS = 8'h20;
  localparam logic [7:0] OSSR_OFS_APPLIED = 8'h21;
  // ==========================================================
  // field positions
  localparam int OSSR_CH0_LSB = 0;
  localparam int OSSR_CH1_LSB = 4;
  localparam int OSSR_FIELD_W = 4;
  localparam int OSSR_PENDING_BIT = 0;
  localparam int OSSR_RUN_BIT = 1;
  // ==========================================================
  // values after reset
  localparam logic [7:0] OSSR_DAC_RST = 8'h10;
  localparam logic [7:0] OSSR_PDM_RST = 8'h32;
  localparam logic [3:0] OSSR_DAC1_RST = 4'h1;
  localparam logic [3:0] OSSR_DAC0_RST = 4'h0;
  localparam logic [3:0] OSSR_PDM1_RST = 4'h3;
  localparam logic [3:0] OSSR_PDM0_RST = 4'h2;
  // ==========================================================
  // source codes
  localparam logic [3:0] OSSR_SRC_CORE0 = 4'h0;
  localparam logic [3:0] OSSR_SRC_CORE1 = 4'h1;
  localparam logic [3:0] OSSR_SRC_CORE2 = 4'h2;
  localparam logic [3:0] OSSR_SRC_CORE3 = 4'h3;
  localparam logic [3:0] OSSR_SRC_ASRC0 = 4'hC;
  localparam logic [3:0] OSSR_SRC_ASRC1 = 4'hD;
  // ==========================================================
  // stream defaults
  localparam int OSSR_SAMPLE_W = 24;
  localparam int OSSR_FIFO_DEPTH = 16;
endpackage

// >>> ossr_regs.sv
// output source select registers with routed sample stream and frame fifo
// Function
// - dac channel 1 field bits 7:4, reset 1
// - dac channel 0 field bits 3:0, reset 0
// - new dac routing applied only while core halted
// - codes 0-3 core outputs, C/D rate converters
// - pdm channel 1 field bits 7:4, reset 3
// - pdm channel 0 field bits 3:0, reset 2
`timescale 1ns/100ps

// ==========================================================
// frame fifo with registered output stage
module ossr_fifo #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // fill side
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [WIDTH-1:0] s_data,
  // drain side
  output logic m_valid,
  input wire logic m_ready,
  output logic [WIDTH-1:0] m_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, next_wr_ptr;
  logic [PW-1:0] rd_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  // ready is kept in its own flop so the fill side sees a registered signal
  logic in_ready, next_in_ready;
  logic out_valid, next_out_valid;
  logic [WIDTH-1:0] out_data, next_out_data;
  logic push, pop;

  always_comb begin
    push = s_valid && in_ready;
    pop = (!out_valid || m_ready) && (count != '0);
    next_wr_ptr = push ? wr_ptr + PW'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + PW'(1) : rd_ptr;
    next_count = count + CW'(push) - CW'(pop);
    next_in_ready = (next_count != FULL_CNT);
    next_out_valid = out_valid;
    next_out_data = out_data;
    if (pop) begin
      next_out_valid = 1'b1;
      next_out_data = mem[rd_ptr];
    end else if (m_ready) begin
      next_out_valid = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end

  // storage needs no reset, it is only read behind count
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= s_data;
    end
  end

  assign s_ready = in_ready;
  assign m_valid = out_valid;
  assign m_data = out_data;
endmodule

// ==========================================================
// register bank and source routing
module ossr_regs #(
  parameter int SAMPLE_W = ossr_pkg::OSSR_SAMPLE_W,
  parameter int FIFO_DEPTH = ossr_pkg::OSSR_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // processing core state
  input wire logic core_run,
  // source samples, one frame per handshake
  input wire logic frame_in_valid,
  output logic frame_in_ready,
  input wire logic [SAMPLE_W-1:0] core_out0,
  input wire logic [SAMPLE_W-1:0] core_out1,
  input wire logic [SAMPLE_W-1:0] core_out2,
  input wire logic [SAMPLE_W-1:0] core_out3,
  input wire logic [SAMPLE_W-1:0] asrc_in0,
  input wire logic [SAMPLE_W-1:0] asrc_in1,
  // routed samples
  output logic frame_out_valid,
  input wire logic frame_out_ready,
  output logic [SAMPLE_W-1:0] converter_ch0_sample,
  output logic [SAMPLE_W-1:0] converter_ch1_sample,
  output logic [SAMPLE_W-1:0] modulator_ch0_sample,
  output logic [SAMPLE_W-1:0] modulator_ch1_sample
);
  import ossr_pkg::*;

  localparam int FW = 4 * SAMPLE_W;

  // ==========================================================
  // registers
  logic [7:0] dac_feed_select, next_dac_feed_select;
  logic [7:0] pulse_density_feed_select, next_pulse_density_feed_select;
  logic [7:0] dac_applied, next_dac_applied;
  logic [7:0] rdata, next_rdata;
  logic pending;

  always_comb begin
    next_dac_feed_select = dac_feed_select;
    next_pulse_density_feed_select = pulse_density_feed_select;
    // the halted core picks up the stored routing; a running core keeps the old one
    next_dac_applied = core_run ? dac_applied : dac_feed_select;
    pending = (dac_feed_select != dac_applied);
    if (reg_wr) begin
      if (reg_addr == OSSR_OFS_DAC) begin
        next_dac_feed_select = reg_wdata;
      end else if (reg_addr == OSSR_OFS_PDM) begin
        next_pulse_density_feed_select = reg_wdata;
      end
    end
    next_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == OSSR_OFS_DAC) begin
        next_rdata = dac_feed_select;
      end else if (reg_addr == OSSR_OFS_PDM) begin
        next_rdata = pulse_density_feed_select;
      end else if (reg_addr == OSSR_OFS_STATUS) begin
        next_rdata[OSSR_PENDING_BIT] = pending;
        next_rdata[OSSR_RUN_BIT] = core_run;
      end else if (reg_addr == OSSR_OFS_APPLIED) begin
        next_rdata = dac_applied;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dac_feed_select <= OSSR_DAC_RST;
      pulse_density_feed_select <= OSSR_PDM_RST;
      dac_applied <= OSSR_DAC_RST;
      rdata <= 8'h00;
    end else begin
      dac_feed_select <= next_dac_feed_select;
      pulse_density_feed_select <= next_pulse_density_feed_select;
      dac_applied <= next_dac_applied;
      rdata <= next_rdata;
    end
  end

  assign reg_rdata = rdata;

  // ==========================================================
  // source decode, reserved codes give silence
  function automatic logic [SAMPLE_W-1:0] pick(
    input logic [3:0] code,
    input logic [SAMPLE_W-1:0] c0,
    input logic [SAMPLE_W-1:0] c1,
    input logic [SAMPLE_W-1:0] c2,
    input logic [SAMPLE_W-1:0] c3,
    input logic [SAMPLE_W-1:0] a0,
    input logic [SAMPLE_W-1:0] a1
  );
    logic [SAMPLE_W-1:0] r;
    r = '0;
    case (code)
      OSSR_SRC_CORE0: r = c0;
      OSSR_SRC_CORE1: r = c1;
      OSSR_SRC_CORE2: r = c2;
      OSSR_SRC_CORE3: r = c3;
      OSSR_SRC_ASRC0: r = a0;
      OSSR_SRC_ASRC1: r = a1;
      default: r = '0;
    endcase
    return r;
  endfunction

  logic [3:0] dac0_code, dac1_code, pdm0_code, pdm1_code;
  logic [SAMPLE_W-1:0] route_dac0, route_dac1, route_pdm0, route_pdm1;
  logic [FW-1:0] frame_word;
  logic [FW-1:0] fifo_out;

  always_comb begin
    dac0_code = dac_applied[OSSR_CH0_LSB +: OSSR_FIELD_W];
    dac1_code = dac_applied[OSSR_CH1_LSB +: OSSR_FIELD_W];
    pdm0_code = pulse_density_feed_select[OSSR_CH0_LSB +: OSSR_FIELD_W];
    pdm1_code = pulse_density_feed_select[OSSR_CH1_LSB +: OSSR_FIELD_W];
    route_dac0 = pick(dac0_code, core_out0, core_out1, core_out2, core_out3, asrc_in0, asrc_in1);
    route_dac1 = pick(dac1_code, core_out0, core_out1, core_out2, core_out3, asrc_in0, asrc_in1);
    route_pdm0 = pick(pdm0_code, core_out0, core_out1, core_out2, core_out3, asrc_in0, asrc_in1);
    route_pdm1 = pick(pdm1_code, core_out0, core_out1, core_out2, core_out3, asrc_in0, asrc_in1);
    frame_word = {route_pdm1, route_pdm0, route_dac1, route_dac0};
  end

  ossr_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .s_valid(frame_in_valid),
    .s_ready(frame_in_ready),
    .s_data(frame_word),
    .m_valid(frame_out_valid),
    .m_ready(frame_out_ready),
    .m_data(fifo_out)
  );

  assign converter_ch0_sample = fifo_out[0 +: SAMPLE_W];
  assign converter_ch1_sample = fifo_out[SAMPLE_W +: SAMPLE_W];
  assign modulator_ch0_sample = fifo_out[2*SAMPLE_W +: SAMPLE_W];
  assign modulator_ch1_sample = fifo_out[3*SAMPLE_W +: SAMPLE_W];

  // ==========================================================
  // checks
  property p_dac1_reset;
    @(posedge core_clk) $past(reset) && !reset |-> dac_feed_select[OSSR_CH1_LSB +: OSSR_FIELD_W] == OSSR_DAC1_RST;
  endproperty
  a_dac1_reset: assert property (p_dac1_reset) else $error("dac ch1 field reset wrong");

  property p_dac0_write;
    @(posedge core_clk) disable iff (reset)
      reg_wr && reg_addr == OSSR_OFS_DAC |=> dac_feed_select[3:0] == $past(reg_wdata[3:0]);
  endproperty
  a_dac0_write: assert property (p_dac0_write) else $error("dac ch0 field not written");

  property p_dac1_write;
    @(posedge core_clk) disable iff (reset)
      reg_wr && reg_addr == OSSR_OFS_DAC |=> dac_feed_select[7:4] == $past(reg_wdata[7:4]);
  endproperty
  a_dac1_write: assert property (p_dac1_write) else $error("dac ch1 field not written");

  property p_hold_running;
    @(posedge core_clk) disable iff (reset)
      core_run |=> dac_applied == $past(dac_applied);
  endproperty
  a_hold_running: assert property (p_hold_running) else $error("dac routing moved while core ran");

  property p_apply_halted;
    @(posedge core_clk) disable iff (reset)
      !core_run ##1 !core_run |-> dac_applied == $past(dac_feed_select);
  endproperty
  a_apply_halted: assert property (p_apply_halted) else $error("dac routing not applied when halted");

  property p_route_asrc1;
    @(posedge core_clk) disable iff (reset)
      dac1_code == OSSR_SRC_ASRC1 |-> route_dac1 == asrc_in1;
  endproperty
  a_route_asrc1: assert property (p_route_asrc1) else $error("asrc1 not routed to dac ch1");

  property p_route_core2;
    @(posedge core_clk) disable iff (reset)
      pdm0_code == OSSR_SRC_CORE2 |-> route_pdm0 == core_out2;
  endproperty
  a_route_core2: assert property (p_route_core2) else $error("core output 2 not routed to pdm ch0");

  property p_route_reserved;
    @(posedge core_clk) disable iff (reset)
      pdm0_code inside {[4'h4:4'hB], 4'hE, 4'hF} |-> route_pdm0 == '0;
  endproperty
  a_route_reserved: assert property (p_route_reserved) else $error("reserved code not silent");

  property p_pdm_reset;
    @(posedge core_clk) $past(reset) && !reset |-> pulse_density_feed_select == {OSSR_PDM1_RST, OSSR_PDM0_RST};
  endproperty
  a_pdm_reset: assert property (p_pdm_reset) else $error("pdm fields reset wrong");

  property p_pdm1_write;
    @(posedge core_clk) disable iff (reset)
      reg_wr && reg_addr == OSSR_OFS_PDM |=> pulse_density_feed_select[7:4] == $past(reg_wdata[7:4]);
  endproperty
  a_pdm1_write: assert property (p_pdm1_write) else $error("pdm ch1 field not written");

  property p_pdm_readback;
    @(posedge core_clk) disable iff (reset)
      reg_wr && reg_addr == OSSR_OFS_PDM ##1 reg_rd && reg_addr == OSSR_OFS_PDM |=>
        reg_rdata[3:0] == $past(reg_wdata[3:0], 2);
  endproperty
  a_pdm_readback: assert property (p_pdm_readback) else $error("pdm ch0 readback wrong");
endmodule

// >>> ossr_regs_tb_top.sv
// self-checking testbench for the output source select register bank
`timescale 1ns/100ps
`define CHK(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR %s expected %h seen %h", name, exp, got); end end

module ossr_regs_tb_top;
  import ossr_pkg::*;
  // ==========================================================
  // signals
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic core_run = 1'b0;
  logic frame_in_valid = 1'b0;
  logic frame_in_ready;
  logic frame_out_valid;
  logic frame_out_ready = 1'b1;
  logic [15:0] tag = 16'h0000;
  logic [23:0] cd0, cd1, pm0, pm1;
  int errors = 0;
  int n_compared = 0;
  int cnt;
  // source samples carry the frame tag and a source id
  ossr_regs u_ossr_regs (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_run(core_run),
    .frame_in_valid(frame_in_valid), .frame_in_ready(frame_in_ready), .core_out0({tag, 8'h00}),
    .core_out1({tag, 8'h01}), .core_out2({tag, 8'h02}), .core_out3({tag, 8'h03}),
    .asrc_in0({tag, 8'hA0}), .asrc_in1({tag, 8'hA1}), .frame_out_valid(frame_out_valid),
    .frame_out_ready(frame_out_ready), .converter_ch0_sample(cd0), .converter_ch1_sample(cd1),
    .modulator_ch0_sample(pm0), .modulator_ch1_sample(pm1));
  // ==========================================================
  // helpers
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [23:0] exp_src(logic [3:0] c, logic [15:0] t);
    case (c)
      OSSR_SRC_CORE0, OSSR_SRC_CORE1, OSSR_SRC_CORE2, OSSR_SRC_CORE3: exp_src = {t, 4'h0, c};
      OSSR_SRC_ASRC0: exp_src = {t, 8'hA0};
      OSSR_SRC_ASRC1: exp_src = {t, 8'hA1};
      default: exp_src = 24'h00_0000;
    endcase
  endfunction
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  // write followed by a read of the same address with no idle cycle
  task automatic wr_rd(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    `CHK("reg_rdata", d, reg_rdata)
  endtask
  task automatic send_frame(logic [15:0] t);
    @(posedge core_clk);
    tag <= t;
    frame_in_valid <= 1'b1;
    do @(posedge core_clk); while (frame_in_ready !== 1'b1);
    frame_in_valid <= 1'b0;
  endtask
  task automatic check_frame(logic [7:0] dac, logic [7:0] pdm, logic [15:0] t);
    cnt = 0;
    do begin
      @(posedge core_clk);
      cnt++;
    end while (frame_out_valid !== 1'b1 && cnt < 40);
    `CHK("frame_out_valid", 1'b1, frame_out_valid)
    `CHK("converter_ch0_sample", exp_src(dac[3:0], t), cd0)
    `CHK("converter_ch1_sample", exp_src(dac[7:4], t), cd1)
    `CHK("modulator_ch0_sample", exp_src(pdm[3:0], t), pm0)
    `CHK("modulator_ch1_sample", exp_src(pdm[7:4], t), pm1)
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset_values;
    `CHK("frame_in_ready", 1'b1, frame_in_ready)
    `CHK("frame_out_valid", 1'b0, frame_out_valid)
    rd(OSSR_OFS_DAC, 8'h10);
    rd(OSSR_OFS_PDM, 8'h32);
    rd(OSSR_OFS_APPLIED, 8'h10);
    wr(8'h30, 8'hA5);
    rd(8'h30, 8'h00);
    check_frame_after_send(8'h10, 8'h32, 16'h0001);
    $display("test reset_values done");
  endtask
  task automatic check_frame_after_send(logic [7:0] dac, logic [7:0] pdm, logic [15:0] t);
    send_frame(t);
    check_frame(dac, pdm, t);
  endtask
  task automatic t_routing;
    // reserved codes are left out on purpose
    logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hC, 4'hD};
    for (int i = 0; i < 6; i++) begin
      wr(OSSR_OFS_DAC, {codes[(i + 1) % 6], codes[i]});
      rd(OSSR_OFS_DAC, {codes[(i + 1) % 6], codes[i]});
      wr_rd(OSSR_OFS_PDM, {codes[i], codes[(i + 2) % 6]});
      check_frame_after_send({codes[(i + 1) % 6], codes[i]}, {codes[i], codes[(i + 2) % 6]},
        16'h0010 + 16'(i));
    end
    $display("test routing done");
  endtask
  task automatic t_core_running;
    wr(OSSR_OFS_DAC, 8'h10);
    wr(OSSR_OFS_PDM, 8'h32);
    // the write lands while halted, the core starts on the very next edge
    wr(OSSR_OFS_DAC, 8'hDC);
    core_run <= 1'b1;
    rd(OSSR_OFS_DAC, 8'hDC);
    rd(OSSR_OFS_STATUS, 8'h03);
    rd(OSSR_OFS_APPLIED, 8'h10);
    check_frame_after_send(8'h10, 8'h32, 16'h0020);
    @(posedge core_clk);
    core_run <= 1'b0;
    rd(OSSR_OFS_STATUS, 8'h00);
    rd(OSSR_OFS_APPLIED, 8'hDC);
    check_frame_after_send(8'hDC, 8'h32, 16'h0021);
    $display("test core_running done");
  endtask
  task automatic t_fifo_fill;
    int acc;
    acc = 0;
    @(posedge core_clk);
    frame_out_ready <= 1'b0;
    frame_in_valid <= 1'b1;
    tag <= 16'h0100;
    for (int k = 0; k < 24; k++) begin
      @(posedge core_clk);
      if (frame_in_ready === 1'b1) begin
        acc++;
        tag <= 16'h0100 + 16'(acc);
      end
    end
    frame_in_valid <= 1'b0;
    `CHK("frames_accepted", OSSR_FIFO_DEPTH + 1, acc)
    @(posedge core_clk);
    frame_out_ready <= 1'b1;
    for (int k = 0; k < 17; k++) begin
      check_frame(8'hDC, 8'h32, 16'h0100 + 16'(k));
    end
    @(posedge core_clk);
    `CHK("frame_out_valid", 1'b0, frame_out_valid)
    $display("test fifo_fill done");
  endtask
  // ==========================================================
  // verdict
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #200us;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset_values();
    t_routing();
    t_core_running();
    t_fifo_fill();
    end_of_test();
  end
endmodule
